// File: rtl/acc_pkg.sv
// constants and carrier types for the conversion control block
package acc_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ACC_OFS_CTRL = 8'h00;
   localparam logic [7:0] ACC_OFS_CTRL2 = 8'h04;
   localparam logic [7:0] ACC_OFS_RES_HI = 8'h08;
   localparam logic [7:0] ACC_OFS_RES_LO = 8'h0C;
   localparam logic [7:0] ACC_OFS_CMP_HI = 8'h10;
   localparam logic [7:0] ACC_OFS_CMP_LO = 8'h14;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ACC_BIT_DONE = 7;
   localparam int ACC_BIT_IRQ_EN = 6;
   localparam int ACC_BIT_CONT = 5;
   localparam int ACC_BIT_ACTIVE = 7;
   localparam int ACC_BIT_TRIG = 6;
   localparam int ACC_BIT_CMP_EN = 5;
   localparam int ACC_BIT_CMP_GE = 4;
   // ----------------------------------------------------------------
   // channel codes, reset values and bus response codes
   // ----------------------------------------------------------------
   localparam logic [4:0] ACC_CH_AIN_END = 5'h1C;
   localparam logic [4:0] ACC_CH_REF_HI = 5'h1D;
   localparam logic [4:0] ACC_CH_REF_LO = 5'h1E;
   localparam logic [4:0] ACC_CH_OFF = 5'h1F;
   localparam logic [4:0] ACC_CH_RST = 5'h1F;
   localparam logic [9:0] ACC_CMP_RST = 10'h000;
   localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic start;
      logic abort;
      logic power_down;
      logic [4:0] channel;
   } acc_core_req_t;
   typedef struct packed {
      logic done;
      logic [9:0] data;
   } acc_core_rsp_t;
   typedef struct packed {
      logic [27:0] ain;
      logic ref_hi;
      logic ref_lo;
      logic off;
   } acc_mux_t;
endpackage

// File: rtl/acc_chan_decode.sv
// channel code to analog input selection decoder
`timescale 1ns/1ns
`default_nettype none
module acc_chan_decode
   import acc_pkg::*;
(
   input wire logic [4:0] code,
   output acc_mux_t sel
);
   always_comb begin
      sel = '0;
      if (code < ACC_CH_AIN_END) begin
         sel.ain[code] = 1'b1;
      end else if (code == ACC_CH_REF_HI) begin
         sel.ref_hi = 1'b1;
      end else if (code == ACC_CH_REF_LO) begin
         sel.ref_lo = 1'b1;
      end else if (code == ACC_CH_OFF) begin
         sel.off = 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: rtl/acc_ctrl.sv
// conversion control and status with an AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - control write aborts a running conversion and restarts unless channel all ones; with trigger select 1 it waits for a trigger
// - compare off: done flag sets on every completed conversion
// - compare on: done flag sets only when compare holds
// - done flag clears on control write or result low read
// - interrupt asserts when done flag sets with interrupt enable high
// - continuous off: one conversion per write or per hardware trigger
// - continuous on: conversions repeat back to back after the start
// - channel field bits 4:0, codes 0 to 27 pick inputs 0 to 27
// - twenty-eight analog inputs are selectable
// - channel all ones turns converter off and isolates inputs
// - ending continuous mode via all ones starts no extra conversion
// - single mode drops to low power after each conversion
// - trigger select 0 software write start, 1 hardware trigger start
// - compare direction 0 below value, 1 greater or equal
// - active flag sets on start, clears on single-mode completion or on an abort that is not followed by a restart
module acc_ctrl
   import acc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic hw_trigger_input,
   input wire acc_core_rsp_t core_rsp,
   output acc_core_req_t core_req,
   output acc_mux_t analog_channel_inputs,
   output logic done_irq
);
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} acc_state_t;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic [7:0] waddr_r, waddr_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic arready_r, arready_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic wr_fire, wr_hit, rd_fire, rd_hit;
   logic ctrl_wr, ctrl2_wr, rl_rd;
   logic [7:0] rd_byte;

   // control state
   acc_state_t st_r, st_nxt;
   logic irq_en_r, irq_en_nxt, cont_r, cont_nxt;
   logic [4:0] chan_r, chan_nxt;
   logic trig_sel_r, trig_sel_nxt, cmp_en_r, cmp_en_nxt;
   logic cmp_ge_r, cmp_ge_nxt;
   logic [9:0] cmp_r, cmp_nxt, result_r, result_nxt;
   logic done_r, done_nxt, irq_r, irq_nxt, trig_q_r, trig_q_nxt;
   acc_core_req_t req_r, req_nxt;
   acc_mux_t mux_r, mux_dec;
   logic conv_end, cmp_true, done_set, trig_rise;

   assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
   assign rd_fire = s_axi_arvalid && arready_r;
   assign ctrl_wr = wr_fire && wstrb_r && (waddr_r == ACC_OFS_CTRL);
   assign ctrl2_wr = wr_fire && wstrb_r && (waddr_r == ACC_OFS_CTRL2);
   assign rl_rd = rd_fire && (s_axi_araddr == ACC_OFS_RES_LO);

   always_comb begin
      wr_hit = 1'b1;
      unique case (waddr_r)
         ACC_OFS_CTRL, ACC_OFS_CTRL2, ACC_OFS_CMP_HI, ACC_OFS_CMP_LO: ;
         ACC_OFS_RES_HI, ACC_OFS_RES_LO: ;
         default: wr_hit = 1'b0;
      endcase
   end

   always_comb begin
      rd_hit = 1'b1;
      rd_byte = 8'h00;
      unique case (s_axi_araddr)
         ACC_OFS_CTRL: rd_byte = {done_r, irq_en_r, cont_r, chan_r};
         ACC_OFS_CTRL2: begin
            rd_byte[ACC_BIT_ACTIVE] = (st_r == ST_CONV);
            rd_byte[ACC_BIT_TRIG] = trig_sel_r;
            rd_byte[ACC_BIT_CMP_EN] = cmp_en_r;
            rd_byte[ACC_BIT_CMP_GE] = cmp_ge_r;
         end
         ACC_OFS_RES_HI: rd_byte = {6'h00, result_r[9:8]};
         ACC_OFS_RES_LO: rd_byte = result_r[7:0];
         ACC_OFS_CMP_HI: rd_byte = {6'h00, cmp_r[9:8]};
         ACC_OFS_CMP_LO: rd_byte = cmp_r[7:0];
         default: rd_hit = 1'b0;
      endcase
   end

   always_comb begin
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_awvalid && awready_r) begin
         aw_got_nxt = 1'b1;
         waddr_nxt = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && wready_r) begin
         w_got_nxt = 1'b1;
         wdata_nxt = s_axi_wdata[7:0];
         wstrb_nxt = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (rd_fire) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_byte;
         rresp_nxt = rd_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      awready_nxt = !aw_got_nxt && !bvalid_nxt;
      wready_nxt = !w_got_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         waddr_r <= 8'h00;
         wdata_r <= 8'h00;
         wstrb_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= ACC_RESP_OKAY;
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 8'h00;
         rresp_r <= ACC_RESP_OKAY;
      end else begin
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // ----------------------------------------------------------------
   // conversion sequencing
   // ----------------------------------------------------------------
   assign conv_end = core_rsp.done && (st_r == ST_CONV);
   assign trig_rise = hw_trigger_input && !trig_q_r;
   assign cmp_true = cmp_ge_r ? (core_rsp.data >= cmp_r)
                              : (core_rsp.data < cmp_r);
   assign done_set = conv_end && (!cmp_en_r || cmp_true);

   acc_chan_decode u_dec (
      .code(chan_nxt),
      .sel(mux_dec)
   );

   always_comb begin
      irq_en_nxt = irq_en_r;
      cont_nxt = cont_r;
      chan_nxt = chan_r;
      trig_sel_nxt = trig_sel_r;
      cmp_en_nxt = cmp_en_r;
      cmp_ge_nxt = cmp_ge_r;
      cmp_nxt = cmp_r;
      result_nxt = result_r;
      st_nxt = st_r;
      trig_q_nxt = hw_trigger_input;
      req_nxt = '0;
      if (done_set) begin
         result_nxt = core_rsp.data;
      end
      if (conv_end) begin
         if (cont_r) begin
            req_nxt.start = 1'b1;
         end else begin
            st_nxt = trig_sel_r ? ST_WAIT : ST_IDLE;
         end
      end
      if (st_r == ST_WAIT && trig_rise) begin
         st_nxt = ST_CONV;
         req_nxt.start = 1'b1;
      end
      if (ctrl2_wr) begin
         trig_sel_nxt = wdata_r[ACC_BIT_TRIG];
         cmp_en_nxt = wdata_r[ACC_BIT_CMP_EN];
         cmp_ge_nxt = wdata_r[ACC_BIT_CMP_GE];
      end
      if (wr_fire && wstrb_r && waddr_r == ACC_OFS_CMP_HI) begin
         cmp_nxt[9:8] = wdata_r[1:0];
      end
      if (wr_fire && wstrb_r && waddr_r == ACC_OFS_CMP_LO) begin
         cmp_nxt[7:0] = wdata_r;
      end
      if (ctrl_wr) begin
         irq_en_nxt = wdata_r[ACC_BIT_IRQ_EN];
         cont_nxt = wdata_r[ACC_BIT_CONT];
         chan_nxt = wdata_r[4:0];
         req_nxt.abort = (st_r == ST_CONV);
         req_nxt.start = 1'b0;
         if (wdata_r[4:0] == ACC_CH_OFF) begin
            st_nxt = ST_IDLE;
         end else if (!trig_sel_r) begin
            st_nxt = ST_CONV;
            req_nxt.start = 1'b1;
         end else begin
            st_nxt = ST_WAIT;
         end
      end
      done_nxt = done_set || (done_r && !(ctrl_wr || rl_rd));
      irq_nxt = done_nxt && irq_en_nxt;
      req_nxt.channel = chan_nxt;
      req_nxt.power_down = (st_nxt != ST_CONV);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ST_IDLE;
         irq_en_r <= 1'b0;
         cont_r <= 1'b0;
         chan_r <= ACC_CH_RST;
         trig_sel_r <= 1'b0;
         cmp_en_r <= 1'b0;
         cmp_ge_r <= 1'b0;
         cmp_r <= ACC_CMP_RST;
         result_r <= 10'h000;
         done_r <= 1'b0;
         irq_r <= 1'b0;
         trig_q_r <= 1'b0;
         req_r <= '{start: 1'b0, abort: 1'b0, power_down: 1'b1,
                    channel: ACC_CH_RST};
         mux_r <= '{ain: 28'h0000000, ref_hi: 1'b0, ref_lo: 1'b0,
                    off: 1'b1};
      end else begin
         st_r <= st_nxt;
         irq_en_r <= irq_en_nxt;
         cont_r <= cont_nxt;
         chan_r <= chan_nxt;
         trig_sel_r <= trig_sel_nxt;
         cmp_en_r <= cmp_en_nxt;
         cmp_ge_r <= cmp_ge_nxt;
         cmp_r <= cmp_nxt;
         result_r <= result_nxt;
         done_r <= done_nxt;
         irq_r <= irq_nxt;
         trig_q_r <= trig_q_nxt;
         req_r <= req_nxt;
         mux_r <= mux_dec;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = {24'h000000, rdata_r};
   assign core_req = req_r;
   assign analog_channel_inputs = mux_r;
   assign done_irq = irq_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_write_restarts: assert property (
      ctrl_wr && wdata_r[4:0] != ACC_CH_OFF && !trig_sel_r
      |=> core_req.start && st_r == ST_CONV && !core_req.power_down)
      else $error("control write did not restart conversion");
   chk_done_plain: assert property (
      conv_end && !cmp_en_r |=> done_r && result_r == $past(core_rsp.data))
      else $error("done flag missing after conversion");
   chk_done_cmp_false: assert property (
      conv_end && cmp_en_r && !cmp_true && !done_r |=> !done_r)
      else $error("done flag set with compare false");
   chk_done_clear: assert property (
      (ctrl_wr || rl_rd) && !conv_end |=> !done_r)
      else $error("done flag not cleared");
   chk_irq_raise: assert property (
      $rose(done_r) && irq_en_r |-> done_irq)
      else $error("interrupt not raised on done");
   // a new start in the second cycle is legal only after a write or trigger
   chk_single_rest: assert property (
      conv_end && !cont_r && !ctrl_wr
      |=> (!core_req.start && core_req.power_down)
          ##1 (core_req.power_down || $past(ctrl_wr) || $past(trig_rise)))
      else $error("single mode converted again");
   chk_cont_repeat: assert property (
      conv_end && cont_r && !ctrl_wr
      |=> core_req.start ##1 (st_r == ST_CONV || $past(ctrl_wr)))
      else $error("continuous mode did not repeat");
   chk_off_isolate: assert property (
      ctrl_wr && wdata_r[4:0] == ACC_CH_OFF
      |=> analog_channel_inputs.off && analog_channel_inputs.ain == '0
          && !core_req.start && st_r == ST_IDLE)
      else $error("off code did not isolate");
   chk_decode_low: assert property (
      chan_r < ACC_CH_AIN_END |-> analog_channel_inputs.ain == 28'(1) << chan_r)
      else $error("channel decode wrong");
   chk_hw_start: assert property (
      st_r == ST_WAIT && trig_rise && !ctrl_wr |=> core_req.start)
      else $error("hardware trigger ignored");
   chk_abort_flag: assert property (
      ctrl_wr && st_r == ST_CONV |=> core_req.abort)
      else $error("abort not signalled");

   cov_sw_single: cover property (ctrl_wr && !trig_sel_r ##[1:50] conv_end);
   cov_hw_start: cover property (st_r == ST_WAIT && trig_rise);
   cov_cont_loop: cover property (conv_end && cont_r);
   cov_cmp_hit: cover property (done_set && cmp_en_r);
endmodule
`default_nettype wire

// File: dv/acc_core_model.sv
// behavioural model of the analog converter core
`timescale 1ns/1ns
`default_nettype none
module acc_core_model
   import acc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire acc_core_req_t core_req,
   input wire logic [7:0] lat,
   input wire logic [9:0] value,
   output acc_core_rsp_t core_rsp
);
   // ---------------------------------------------------------------
   // conversion timer
   // ---------------------------------------------------------------
   logic busy_r;
   logic [7:0] cnt_r;
   // data toggles outside done so a sample taken one cycle after done is never a match
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_r <= 1'b0;
         cnt_r <= 8'h00;
         core_rsp <= '0;
      end else begin
         core_rsp.done <= 1'b0;
         core_rsp.data <= ~core_rsp.data;
         if (core_req.start) begin
            busy_r <= 1'b1;
            cnt_r <= lat;
         end else if (core_req.abort || core_req.power_down) begin
            busy_r <= 1'b0;
         end else if (busy_r && cnt_r == 8'h00) begin
            busy_r <= 1'b0;
            core_rsp.done <= 1'b1;
            core_rsp.data <= value;
         end else if (busy_r) begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/acc_ctrl_tb_top.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ns
`default_nettype none
module acc_ctrl_tb_top import acc_pkg::*;;
   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic hw = 1'b0;
   logic [7:0] lat = 8'h02;
   logic [9:0] value = 10'h000;
   logic awready, wready, bvalid, arready, rvalid, done_irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   acc_core_req_t core_req;
   acc_core_rsp_t core_rsp;
   acc_mux_t mux;
   logic [33:0] exp_q[$];
   int bad_count = 0;
   int compares = 0;
   int starts = 0;
   int aborts = 0;
   int unsigned seed;

   always #50 aclk = ~aclk;

   acc_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .hw_trigger_input(hw), .core_rsp(core_rsp), .core_req(core_req),
      .analog_channel_inputs(mux), .done_irq(done_irq));

   acc_core_model u_core (.aclk(aclk), .aresetn(aresetn),
      .core_req(core_req), .lat(lat), .value(value), .core_rsp(core_rsp));

   // ---------------------------------------------------------------
   // checking and bus tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic timeout();
      bad_count++;
      $display("mismatch at %0t: wait ran out", $time);
      finish_test();
   endtask

   task automatic cmp_sig(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic cmp_read(input logic [33:0] got, input logic [33:0] want);
      compares++;
      if (got !== want) begin
         bad_count++;
         $display("mismatch at %0t: read %h want %h", $time, got, want);
      end
   endtask

   // write and read keep each valid up until its ready edge, and ready up until the answer edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 50) timeout();
      bready <= 1'b0;
      cmp_sig(32'(bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      @(posedge aclk);
      exp_q.push_back({er, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 50) timeout();
      rready <= 1'b0;
   endtask

   always @(posedge aclk) begin
      if (rvalid && rready) begin
         if (exp_q.size() > 0) cmp_read({rresp, rdata}, exp_q.pop_front());
         else cmp_read({rresp, rdata}, ~{rresp, rdata});
      end
   end

   always @(posedge aclk) begin
      if (aresetn && core_req.start) starts <= starts + 1;
      if (aresetn && core_req.abort) aborts <= aborts + 1;
   end

   task automatic cyc(input int c);
      repeat (c) @(posedge aclk);
   endtask

   task automatic wait_idle();
      int n;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (core_req.power_down) break;
      end
      if (n == 200) timeout();
   endtask

   function automatic acc_mux_t exp_mux(input logic [4:0] c);
      acc_mux_t m;
      m = '0;
      if (c < ACC_CH_AIN_END) m.ain[c] = 1'b1;
      else if (c == ACC_CH_REF_HI) m.ref_hi = 1'b1;
      else if (c == ACC_CH_REF_LO) m.ref_lo = 1'b1;
      else if (c == ACC_CH_OFF) m.off = 1'b1;
      return m;
   endfunction

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      int i;
      int s0;
      int a0;
      seed = $urandom(32'h2960);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      cmp_sig(32'(mux), 32'(exp_mux(ACC_CH_OFF)));
      rd(ACC_OFS_CTRL, 32'h1F, ACC_RESP_OKAY);
      rd(8'h18, 32'h0, ACC_RESP_SLVERR);
      wr(8'h1C, 8'h00, ACC_RESP_SLVERR);
      wr(ACC_OFS_CTRL2, 8'h00, ACC_RESP_OKAY);
      for (i = 0; i < 32; i++) begin
         wr(ACC_OFS_CTRL, 8'(i), ACC_RESP_OKAY);
         cyc(1);
         cmp_sig(32'(mux), 32'(exp_mux(5'(i))));
         cmp_sig(32'(core_req.channel), 32'(i));
      end
      // single software conversion with the interrupt enabled
      value <= 10'($urandom);
      s0 = starts;
      wr(ACC_OFS_CTRL, 8'h43, ACC_RESP_OKAY);
      wait_idle();
      cyc(3);
      cmp_sig(32'(starts == s0 + 1), 32'h1);
      cmp_sig(32'(done_irq), 32'h1);
      cmp_sig(32'(core_req.power_down), 32'h1);
      rd(ACC_OFS_CTRL, 32'hC3, ACC_RESP_OKAY);
      rd(ACC_OFS_RES_HI, {30'h0, value[9:8]}, ACC_RESP_OKAY);
      rd(ACC_OFS_RES_LO, {24'h0, value[7:0]}, ACC_RESP_OKAY);
      rd(ACC_OFS_CTRL, 32'h43, ACC_RESP_OKAY);
      cmp_sig(32'(done_irq), 32'h0);
      // compare both directions on either side of the threshold
      wr(ACC_OFS_CMP_HI, 8'h01, ACC_RESP_OKAY);
      wr(ACC_OFS_CMP_LO, 8'h00, ACC_RESP_OKAY);
      for (i = 0; i < 4; i++) begin
         value <= i[0] ? 10'h100 : 10'h0FF;
         wr(ACC_OFS_CTRL2, {2'b00, 1'b1, i[1], 4'h0}, ACC_RESP_OKAY);
         wr(ACC_OFS_CTRL, 8'h02, ACC_RESP_OKAY);
         wait_idle();
         cyc(2);
         rd(ACC_OFS_CTRL, {24'h0, i[1] == i[0], 7'h02}, ACC_RESP_OKAY);
      end
      wr(ACC_OFS_CTRL2, 8'h00, ACC_RESP_OKAY);
      // continuous run, then stopped by the off code
      lat <= 8'h03;
      s0 = starts;
      wr(ACC_OFS_CTRL, 8'h25, ACC_RESP_OKAY);
      cyc(40);
      cmp_sig(32'(starts - s0 >= 4), 32'h1);
      wr(ACC_OFS_CTRL, 8'h3F, ACC_RESP_OKAY);
      // taken before the pulse that the stopping write could raise is counted
      s0 = starts;
      cyc(32);
      cmp_sig(32'(starts == s0), 32'h1);
      cmp_sig(32'(core_req.power_down), 32'h1);
      // rewrite during a slow conversion
      lat <= 8'h3C;
      wr(ACC_OFS_CTRL, 8'h06, ACC_RESP_OKAY);
      cyc(1);
      s0 = starts;
      a0 = aborts;
      rd(ACC_OFS_CTRL2, 32'h80, ACC_RESP_OKAY);
      wr(ACC_OFS_CTRL, 8'h06, ACC_RESP_OKAY);
      cyc(1);
      cmp_sig(32'(aborts == a0 + 1), 32'h1);
      cmp_sig(32'(starts == s0 + 1), 32'h1);
      wr(ACC_OFS_CTRL, 8'h1F, ACC_RESP_OKAY);
      cyc(1);
      rd(ACC_OFS_CTRL2, 32'h00, ACC_RESP_OKAY);
      cmp_sig(32'(aborts == a0 + 2), 32'h1);
      // hardware trigger: one conversion per rising edge
      lat <= 8'h03;
      wr(ACC_OFS_CTRL2, 8'h40, ACC_RESP_OKAY);
      s0 = starts;
      wr(ACC_OFS_CTRL, 8'h07, ACC_RESP_OKAY);
      cyc(10);
      cmp_sig(32'(starts == s0), 32'h1);
      for (i = 0; i < 2; i++) begin
         hw <= 1'b1;
         cyc(4);
         hw <= 1'b0;
         wait_idle();
         cyc(2);
         cmp_sig(32'(starts == s0 + i + 1), 32'h1);
      end
      finish_test();
   end
endmodule
`default_nettype wire
